// File: core/sfc_pkg.sv
// Purpose : Shared constants for the serial flash command interpreter.
// Assumes : Core clock pclk at 200 MHz.
// Notes   : Register map, command codes, timing counts and field layout.
package sfc_pkg;

  // ***********************************************************
  // Clock and timing
  // ***********************************************************
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SLEEP_ENTRY_NS   = 3000;   // sleep_entry_delay, least
  localparam int unsigned WAKE_DELAY_NS    = 8000;   // wake_delay, least
  localparam int unsigned SUSPEND_MAX_NS   = 20000;  // suspend latency, longest
  localparam int unsigned RESUME_MAX_NS    = 200;    // resume latency, longest
  localparam int unsigned SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_DELAY_CYC   = (WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SUSPEND_CYC      = (SUSPEND_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESUME_CYC       = (RESUME_MAX_NS * CLK_MHZ) / 1000;

  // ***********************************************************
  // Register map (byte addresses) and fields
  // ***********************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CLEAR  = 8'h0C;
  localparam int unsigned CTRL_BP_LSB   = 0;  // block_protect_bit2..0 in [2:0]
  localparam int unsigned CTRL_FAST     = 3;  // serial clock above 104 MHz
  localparam int unsigned CTRL_ADDR4    = 4;  // 32-bit address mode
  localparam int unsigned CTRL_WRAP_LSB = 5;  // wrap length in [6:5]
  localparam int unsigned START_PROG    = 0;
  localparam int unsigned START_SERASE  = 1;
  localparam logic [6:0] CTRL_RESET     = 7'h00;

  // ***********************************************************
  // Command codes
  // ***********************************************************
  localparam logic [7:0] CMD_WRITE_ENABLE_CMD    = 8'h06;  // write_enable_cmd
  localparam logic [7:0] CMD_WRDIS   = 8'h04;
  localparam logic [7:0] CMD_CE_A    = 8'h60;
  localparam logic [7:0] CMD_CE_B    = 8'hC7;
  localparam logic [7:0] CMD_QPI_ON  = 8'h38;
  localparam logic [7:0] CMD_QPI_OFF = 8'hFF;
  localparam logic [7:0] CMD_SLEEP   = 8'hB9;  // deep_sleep_cmd
  localparam logic [7:0] CMD_WAKE    = 8'hAB;
  localparam logic [7:0] CMD_RST_EN  = 8'h66;
  localparam logic [7:0] CMD_RST     = 8'h99;
  localparam logic [7:0] CMD_UID     = 8'h4B;
  localparam logic [7:0] CMD_ID_A    = 8'h9F;  // identification_read
  localparam logic [7:0] CMD_ID_B    = 8'h9E;
  localparam logic [7:0] CMD_SUSP    = 8'h75;  // operation_suspend_cmd
  localparam logic [7:0] CMD_RESUME  = 8'h7A;  // operation_resume_cmd

  // Frame lengths in serial clocks
  localparam logic [7:0] LEN_CMD_SPI = 8'h08;
  localparam logic [7:0] LEN_CMD_QPI = 8'h02;
  localparam logic [7:0] LEN_HS_DUMMY = 8'h08;
  localparam logic [7:0] LEN_UID_SPI3 = 8'h28;  // cmd + 24 addr + 8 dummy
  localparam logic [7:0] LEN_UID_SPI4 = 8'h30;
  localparam logic [7:0] LEN_UID_QPI3 = 8'h0A;
  localparam logic [7:0] LEN_UID_QPI4 = 8'h0C;

  // Suspend flag positions
  localparam int unsigned SUS_ERASE = 0;
  localparam int unsigned SUS_PROG  = 1;

  typedef enum logic [1:0] {
    SFC_OP_IDLE, SFC_OP_CHIP_ERASE, SFC_OP_PROGRAM, SFC_OP_SECT_ERASE
  } sfc_op_t;

  // Commands refused while a suspend flag is set
  function automatic logic sfc_refused(input logic [7:0] c, input logic [1:0] sus);
    logic base;
    logic prog;
    base = (c == 8'h01) || (c == 8'hB1) || (c == 8'h44) || (c == 8'h20) ||
           (c == 8'h21) || (c == 8'h52) || (c == 8'h5C) || (c == 8'hD8) ||
           (c == 8'hDC) || (c == 8'hC7) || (c == 8'h60);
    prog = (c == 8'h42) || (c == 8'h02) || (c == 8'h12) || (c == 8'h32) ||
           (c == 8'h34) || (c == 8'hC2) || (c == 8'h3E);
    return (|sus && base) || (sus[SUS_PROG] && prog);
  endfunction : sfc_refused

endpackage : sfc_pkg

// File: core/sfc_core.sv
// Purpose : Serial flash command interpreter with APB control and status.
// Assumes : Host drives select, serial clock and data; all sampled by pclk.
// Notes   : Array contents are not modelled; operations are timed only.
//
// What this block does
// RL1 - Whole-array erase takes effect only with the write enable latch set.
// RL2 - Erase and deep sleep run only if select rises right after the byte.
// RL3 - Valid whole-array erase raises write-in-progress until done, clears latch.
// RL4 - Whole-array erase is ignored unless all block protect bits are zero.
// RL5 - Command 38 enters quad instruction mode, FF returns to serial mode.
// RL6 - Mode switches keep write latch, suspend state and wrap length.
// RL7 - Deep sleep is entered only by its command, after a fixed delay.
// RL8 - In deep sleep only release and the reset pair are obeyed.
// RL9 - Deep sleep command during a busy cycle is rejected harmlessly.
// RL10 - After release the device accepts commands only after the wake delay.
// RL11 - Release command is ignored while write-in-progress is set.
// RL12 - Unique ID read: command, zero address, dummy byte, then 128 bits out.
// RL13 - Identification read returns maker, type and capacity bytes on falling edges.
// RL14 - Identification read is not decoded during an erase or program.
// RL15 - Host should not send identification read during deep sleep.
// RL16 - Quad mode above 104 MHz puts eight dummy clocks before identification.
// RL17 - Suspend accepted only during busy program or sector erase with no flag set.
// RL18 - Accepted suspend sets its flag at once, drops busy within the latency.
// RL19 - Program suspend refuses register writes, secure ops, erases and programs.
// RL20 - Erase suspend refuses register writes, secure erase and all erases.
// RL21 - Resume accepted only with a suspend flag set and busy clear.
// RL22 - Accepted resume clears the flag at once, sets busy within 200 ns.
// RL23 - Quad mode carries commands a nibble per clock, high nibble first.
`timescale 1ns/1ps

module sfc_core #(
  parameter int unsigned   FULL_ERASE_CYC = 1000000,  // full_erase_time in cycles
  parameter int unsigned   PROGRAM_CYC    = 8000,
  parameter int unsigned   SECT_ERASE_CYC = 20000,
  parameter logic [7:0]    MAKER_ID       = 8'h5A,    // Arbitrary value
  parameter logic [7:0]    TYPE_ID        = 8'h3C,    // Arbitrary value
  parameter logic [7:0]    CAPACITY_ID    = 8'h21,    // Arbitrary value
  parameter logic [127:0]  UNIQUE_ID      = 128'h0123456789ABCDEF_FEDCBA9876543210
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link from the host
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe
);
  import sfc_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic         sel_s1;
    logic         sel_s2;
    logic         sel_s3;
    logic         clk_s1;
    logic         clk_s2;
    logic         clk_s3;
    logic [3:0]   io_s1;
    logic [3:0]   io_s2;
    logic [7:0]   clk_cnt;
    logic [7:0]   cmd;
    logic         out_on;
    logic         out_arm;
    logic [127:0] out_sr;
    logic         quad_instruction_mode;
    logic         write_enable_latch;
    logic         write_in_progress;
    logic [1:0]   suspend_flags;
    logic         rst_armed;
    logic [2:0]   block_protect;
    logic         fast_clk;
    logic         addr4;
    logic [1:0]   wrap_len;
    sfc_op_t      op;
    logic [31:0]  op_timer;
    logic [15:0]  sus_cnt;
    logic [15:0]  res_cnt;
    logic [15:0]  sleep_cnt;
    logic         deep_sleep;
    logic [15:0]  wake_cnt;
    logic         refused;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [3:0]   io_out;
    logic [3:0]   io_oe;
  } sfc_state_t;

  sfc_state_t s_r;
  sfc_state_t s_nxt;

  // Edge events on the synchronised link
  logic       sck_rise;
  logic       sck_fall;
  logic       sel_rise;
  logic       sel_low;
  logic [7:0] len_cmd;
  logic [7:0] len_id;
  logic [7:0] len_uid;
  logic [7:0] cmd_now;
  logic [7:0] cnt_now;
  logic       mapped;
  logic [31:0] rd_word;

  // Edge detection reads only the second and third flops
  assign sck_rise = s_r.clk_s2 & ~s_r.clk_s3;
  assign sck_fall = ~s_r.clk_s2 & s_r.clk_s3;
  assign sel_rise = s_r.sel_s2 & ~s_r.sel_s3;
  assign sel_low  = ~s_r.sel_s2;

  // Frame lengths depend on the current mode
  assign len_cmd = s_r.quad_instruction_mode ? LEN_CMD_QPI : LEN_CMD_SPI;
  assign len_id  = (s_r.quad_instruction_mode && s_r.fast_clk) ?
                   8'(LEN_CMD_QPI + LEN_HS_DUMMY) : len_cmd;            // see RL16
  assign len_uid = s_r.quad_instruction_mode ?
                   (s_r.addr4 ? LEN_UID_QPI4 : LEN_UID_QPI3) :
                   (s_r.addr4 ? LEN_UID_SPI4 : LEN_UID_SPI3);           // see RL12

  // Command byte as it stands after this rising edge
  always_comb begin
    cmd_now = s_r.cmd;
    if (s_r.clk_cnt < len_cmd) begin
      if (s_r.quad_instruction_mode) begin
        cmd_now = {s_r.cmd[3:0], s_r.io_s2};                            // see RL23
      end else begin
        cmd_now = {s_r.cmd[6:0], s_r.io_s2[0]};
      end
    end
  end
  assign cnt_now = (s_r.clk_cnt == 8'hFF) ? 8'hFF : 8'(s_r.clk_cnt + 8'h01);

  // Register decode and read mux
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_START) ||
                  (paddr == ADDR_STATUS) || (paddr == ADDR_CLEAR);
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL: begin
        rd_word[6:0] = {s_r.wrap_len, s_r.addr4, s_r.fast_clk, s_r.block_protect};
      end
      ADDR_STATUS: begin
        rd_word[7:0] = {s_r.refused, (s_r.wake_cnt != 16'h0000), s_r.deep_sleep,
                        s_r.quad_instruction_mode, s_r.suspend_flags,
                        s_r.write_in_progress, s_r.write_enable_latch};
        rd_word[9:8] = s_r.op;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  always_comb begin
    s_nxt = s_r;

    // Two-flop synchronisers on the host pins
    s_nxt.sel_s1 = sel_n;
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.sel_s3 = s_r.sel_s2;
    s_nxt.clk_s1 = sclk;
    s_nxt.clk_s2 = s_r.clk_s1;
    s_nxt.clk_s3 = s_r.clk_s2;
    s_nxt.io_s1  = io_in;
    s_nxt.io_s2  = s_r.io_s1;

    // APB: one registered wait-free answer in the access phase
    s_nxt.pready = 1'b0;
    if (psel && !penable) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !mapped;
      s_nxt.prdata  = mapped ? rd_word : 32'h0000_0000;
    end
    if (psel && penable && s_r.pready && pwrite && !s_r.pslverr) begin
      case (paddr)
        ADDR_CTRL: begin
          s_nxt.block_protect = pwdata[CTRL_BP_LSB +: 3];
          s_nxt.fast_clk      = pwdata[CTRL_FAST];
          s_nxt.addr4         = pwdata[CTRL_ADDR4];
          s_nxt.wrap_len      = pwdata[CTRL_WRAP_LSB +: 2];
        end
        ADDR_START: begin
          // Local program or sector erase, same guards as its command
          if (s_r.write_enable_latch && !s_r.write_in_progress &&
              s_r.suspend_flags == 2'b00 && !s_r.deep_sleep) begin
            if (pwdata[START_PROG]) begin
              s_nxt.op                 = SFC_OP_PROGRAM;
              s_nxt.op_timer           = PROGRAM_CYC;
              s_nxt.write_in_progress  = 1'b1;
              s_nxt.write_enable_latch = 1'b0;
            end else if (pwdata[START_SERASE]) begin
              s_nxt.op                 = SFC_OP_SECT_ERASE;
              s_nxt.op_timer           = SECT_ERASE_CYC;
              s_nxt.write_in_progress  = 1'b1;
              s_nxt.write_enable_latch = 1'b0;
            end
          end
        end
        ADDR_CLEAR: begin
          if (pwdata[0]) begin
            s_nxt.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Self-timed operation, paused while suspended
    if (s_r.write_in_progress && s_r.suspend_flags == 2'b00) begin
      if (s_r.op_timer <= 32'h0000_0001) begin
        s_nxt.write_in_progress = 1'b0;                                 // see RL3
        s_nxt.op                = SFC_OP_IDLE;
        s_nxt.op_timer          = 32'h0000_0000;
      end else begin
        s_nxt.op_timer = s_r.op_timer - 32'h0000_0001;
      end
    end

    // Suspend latency: busy drops when the count runs out
    if (s_r.sus_cnt != 16'h0000) begin
      s_nxt.sus_cnt = s_r.sus_cnt - 16'h0001;
      if (s_r.sus_cnt == 16'h0001) begin
        s_nxt.write_in_progress = 1'b0;                                 // see RL18
      end
    end

    // Resume latency: busy returns when the count runs out
    if (s_r.res_cnt != 16'h0000) begin
      s_nxt.res_cnt = s_r.res_cnt - 16'h0001;
      if (s_r.res_cnt == 16'h0001) begin
        s_nxt.write_in_progress = 1'b1;                                 // see RL22
      end
    end

    // Deep sleep entry delay
    if (s_r.sleep_cnt != 16'h0000) begin
      s_nxt.sleep_cnt = s_r.sleep_cnt - 16'h0001;
      if (s_r.sleep_cnt == 16'h0001) begin
        s_nxt.deep_sleep = 1'b1;                                        // see RL7
      end
    end

    // Wake delay; commands stay blocked until it ends
    if (s_r.wake_cnt != 16'h0000) begin
      s_nxt.wake_cnt = s_r.wake_cnt - 16'h0001;
      if (s_r.wake_cnt == 16'h0001) begin
        s_nxt.deep_sleep = 1'b0;                                        // see RL10
      end
    end

    // Rising serial clock: shift in and arm the read-out
    if (sel_low && sck_rise) begin
      s_nxt.cmd     = cmd_now;
      s_nxt.clk_cnt = cnt_now;
      if (!s_r.deep_sleep && s_r.wake_cnt == 16'h0000 && !s_r.out_arm) begin
        if ((cmd_now == CMD_ID_A || cmd_now == CMD_ID_B) && cnt_now == len_id &&
            !s_r.write_in_progress) begin                               // see RL14
          s_nxt.out_arm = 1'b1;
          s_nxt.out_sr  = {MAKER_ID, TYPE_ID, CAPACITY_ID, 104'h0};     // see RL13
        end else if (cmd_now == CMD_UID && cnt_now == len_uid) begin
          s_nxt.out_arm = 1'b1;
          s_nxt.out_sr  = UNIQUE_ID;                                    // see RL12
        end
      end
    end

    // Falling serial clock: drive the next bit or nibble
    if (sel_low && sck_fall && s_r.out_arm) begin
      s_nxt.out_on = 1'b1;
      if (s_r.quad_instruction_mode) begin
        s_nxt.io_out = s_r.out_sr[127:124];
        s_nxt.io_oe  = 4'hF;
        s_nxt.out_sr = {s_r.out_sr[123:0], 4'h0};
      end else begin
        s_nxt.io_out = {2'b00, s_r.out_sr[127], 1'b0};                  // see RL13
        s_nxt.io_oe  = 4'h2;
        s_nxt.out_sr = {s_r.out_sr[126:0], 1'b0};
      end
    end

    // Select rising: the frame ends and the command is judged
    if (sel_rise) begin
      s_nxt.clk_cnt = 8'h00;
      s_nxt.cmd     = 8'h00;
      s_nxt.out_on  = 1'b0;
      s_nxt.out_arm = 1'b0;
      s_nxt.io_oe   = 4'h0;
      s_nxt.io_out  = 4'h0;
      if (s_r.clk_cnt >= len_cmd && s_r.wake_cnt == 16'h0000 && !s_r.deep_sleep &&
          sfc_refused(s_r.cmd, s_r.suspend_flags)) begin
        s_nxt.refused = 1'b1;                                           // see RL19, RL20
      end
      if (s_r.clk_cnt == len_cmd && s_r.wake_cnt == 16'h0000) begin     // see RL2, RL10
        if (s_r.deep_sleep) begin
          // Only release and the reset pair are obeyed here
          case (s_r.cmd)
            CMD_WAKE: begin
              if (!s_r.write_in_progress) begin                         // see RL11
                s_nxt.wake_cnt = 16'(WAKE_DELAY_CYC);                   // see RL8
              end
            end
            CMD_RST_EN: begin
              s_nxt.rst_armed = 1'b1;
            end
            CMD_RST: begin
              if (s_r.rst_armed) begin
                s_nxt.deep_sleep         = 1'b0;                        // see RL8
                s_nxt.rst_armed          = 1'b0;
                s_nxt.write_enable_latch = 1'b0;
              end
            end
            default: begin
              s_nxt.rst_armed = 1'b0;
            end
          endcase
        end else begin
          s_nxt.rst_armed = 1'b0;
          case (s_r.cmd)
            CMD_WRITE_ENABLE_CMD: begin
              s_nxt.write_enable_latch = 1'b1;
            end
            CMD_WRDIS: begin
              s_nxt.write_enable_latch = 1'b0;
            end
            CMD_QPI_ON: begin
              s_nxt.quad_instruction_mode = 1'b1;                       // see RL5, RL6
            end
            CMD_QPI_OFF: begin
              s_nxt.quad_instruction_mode = 1'b0;                       // see RL5, RL6
            end
            CMD_CE_A, CMD_CE_B: begin
              if (s_r.write_enable_latch && s_r.block_protect == 3'b000 &&
                  !s_r.write_in_progress && s_r.suspend_flags == 2'b00 &&
                  s_r.res_cnt == 16'h0000) begin                        // see RL1, RL4
                s_nxt.op                 = SFC_OP_CHIP_ERASE;
                s_nxt.op_timer           = FULL_ERASE_CYC;
                s_nxt.write_in_progress  = 1'b1;                        // see RL3
                s_nxt.write_enable_latch = 1'b0;                        // see RL3
              end
            end
            CMD_SLEEP: begin
              if (!s_r.write_in_progress && s_r.sleep_cnt == 16'h0000 &&
                  s_r.res_cnt == 16'h0000) begin                        // see RL9
                s_nxt.sleep_cnt = 16'(SLEEP_ENTRY_CYC);                 // see RL7
              end
            end
            CMD_SUSP: begin
              if (s_r.write_in_progress && s_r.suspend_flags == 2'b00 &&
                  (s_r.op == SFC_OP_PROGRAM || s_r.op == SFC_OP_SECT_ERASE)) begin
                if (s_r.op == SFC_OP_PROGRAM) begin                     // see RL17
                  s_nxt.suspend_flags[SUS_PROG] = 1'b1;                 // see RL18
                end else begin
                  s_nxt.suspend_flags[SUS_ERASE] = 1'b1;                // see RL18
                end
                s_nxt.sus_cnt = 16'(SUSPEND_CYC);
              end
            end
            CMD_RESUME: begin
              if (s_r.suspend_flags != 2'b00 && !s_r.write_in_progress) begin
                s_nxt.suspend_flags = 2'b00;                            // see RL21, RL22
                s_nxt.res_cnt       = 16'(RESUME_CYC);
              end
            end
            CMD_RST_EN: begin
              s_nxt.rst_armed = 1'b1;
            end
            CMD_RST: begin
              if (s_r.rst_armed && !s_r.write_in_progress) begin
                s_nxt.write_enable_latch    = 1'b0;
                s_nxt.quad_instruction_mode = 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r               <= '0;
      s_r.sel_s1        <= 1'b1;
      s_r.sel_s2        <= 1'b1;
      s_r.sel_s3        <= 1'b1;
      s_r.op            <= SFC_OP_IDLE;
      s_r.block_protect <= CTRL_RESET[2:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign io_out  = s_r.io_out;
  assign io_oe   = s_r.io_oe;

endmodule : sfc_core

// File: bench/sfc_properties.sv
// Purpose: Port assertions for sfc_core.
// Assumes: One clock domain, pclk.
// Notes: Attached by the bind below.
`timescale 1ns/1ps
module sfc_properties (
  // Clock and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial link
  input wire logic        sel_n,
  input wire logic        sclk,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no pready");
  chk_ready_idle: assert property (!psel |=> !pready) else $error("stray pready");
  chk_ready_access: assert property (pready |-> psel && penable) else $error("early pready");
  chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved");
  chk_oe_legal: assert property (io_oe inside {4'h0, 4'h2, 4'hF})
    else $error("bad io_oe");
  chk_oe_select: assert property (io_oe != 4'h0 |-> !$past(sel_n, 4))
    else $error("drive while idle");
  chk_out_fall: assert property ($changed(io_out) && io_oe != 4'h0 |-> !sclk)
    else $error("io_out off fall");
  cover property (pready && pslverr);
  cover property (pready && !pslverr);
  cover property (io_oe == 4'h2);
  cover property (io_oe == 4'hF);
endmodule : sfc_properties
bind sfc_core sfc_properties u_sfc_properties (.pclk, .presetn, .psel, .penable, .prdata,
  .pready, .pslverr, .sel_n, .sclk, .io_out, .io_oe);

// File: bench/sfc_host.sv
// Purpose: Host controller model for the link.
// Assumes: Link clock 48 ns, idle low.
// Notes: Unused data lines toggle.
`timescale 1ns/1ps
module sfc_host (
  // Link to the device
  output logic            sel_n,
  output logic            sclk,
  output logic      [3:0] io,
  // Device data
  input  wire logic [3:0] io_out
);
  // Idle link, clock still
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    io = 4'h5;
  end
  // One frame: opcode, extra clocks, read clocks
  task automatic frame(input logic [7:0] op, input logic quad, input int extra,
                       input int nrd, output logic [23:0] rd);
    logic [7:0] sh;
    sh = op;
    rd = 24'h0;
    sel_n = 1'b0;
    for (int i = 0; i < (quad ? 2 : 8) + extra; i++) begin
      sclk = 1'b0;
      io = quad ? sh[7:4] : {~io[3:1], sh[7]};
      sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
      #24;
      sclk = 1'b1;
      #24;
    end
    for (int i = 0; i < nrd; i++) begin
      sclk = 1'b0;
      #24;
      sclk = 1'b1;
      rd = {rd[22:0], io_out[1]};
      #24;
    end
    sclk = 1'b0;
    #24;
    sel_n = 1'b1;
    io = ~io;
    #40;
  endtask : frame
endmodule : sfc_host

// File: bench/testbench.sv
// Purpose: Self-checking bench for sfc_core.
// Assumes: Chip erase and program shortened to 2000, sector erase to 200.
// Notes: sfc_host drives the link.
`timescale 1ns/1ps
module testbench;
  import sfc_pkg::*;
  localparam logic [23:0] ID = 24'hA5C33E; // Arbitrary value
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, st;
  logic        pready, pslverr, sel_n, sclk, e;
  logic [3:0]  io_in, io_out, io_oe;
  logic [23:0] rd;
  int          fails = 0;
  int          checks = 0;
  // Clock
  always #2.5 pclk = ~pclk;
  // Design and host
  sfc_core #(.FULL_ERASE_CYC(2000), .PROGRAM_CYC(2000), .SECT_ERASE_CYC(200),
    .MAKER_ID(ID[23:16]), .TYPE_ID(ID[15:8]), .CAPACITY_ID(ID[7:0]),
    .UNIQUE_ID({ID, 104'h1})) u_sfc_core (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sel_n, .sclk, .io_in, .io_out, .io_oe);
  sfc_host u_sfc_host (.sel_n, .sclk, .io(io_in), .io_out);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stat(input logic [31:0] exp);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(st & 32'h3FF, exp);
  endtask : stat
  task automatic go(input logic [7:0] op, input int extra = 0);
    u_sfc_host.frame(op, 1'b0, extra, 0, rd);
  endtask : go
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic t_erase;
    apb(1'b1, ADDR_CTRL, 32'h1);
    go(CMD_CE_A);
    stat(32'h000);
    go(CMD_WRITE_ENABLE_CMD);
    go(CMD_CE_B);
    stat(32'h001);
    apb(1'b1, ADDR_CTRL, 32'h0);
    go(CMD_CE_A, 1);
    stat(32'h001);
    go(CMD_CE_A);
    stat(32'h102);
    go(CMD_SLEEP);
    cyc(700);
    stat(32'h102);
    cyc(1400);
    stat(32'h000);
    $display("erase test done");
  endtask : t_erase
  task automatic t_mode;
    go(CMD_WRITE_ENABLE_CMD);
    go(CMD_QPI_ON);
    stat(32'h011);
    u_sfc_host.frame(CMD_QPI_OFF, 1'b1, 0, 0, rd);
    stat(32'h001);
    for (int k = 0; k < 2; k++) begin
      u_sfc_host.frame(k ? CMD_ID_B : CMD_ID_A, 1'b0, 0, 24, rd);
      cmp({8'h0, rd}, {8'h0, ID});
    end
    // Unique ID: zero address and dummy byte, top 24 bits read back
    u_sfc_host.frame(CMD_UID, 1'b0, 32, 24, rd);
    cmp({8'h0, rd}, {8'h0, ID});
    // Quad mode above 104 MHz: eight dummy clocks, bit 1 of each nibble
    apb(1'b1, ADDR_CTRL, 32'h8);
    go(CMD_QPI_ON);
    u_sfc_host.frame(CMD_ID_A, 1'b1, 8, 6, rd);
    cmp({8'h0, rd}, 32'h27);
    u_sfc_host.frame(CMD_QPI_OFF, 1'b1, 0, 0, rd);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    cmp({st[30:0], e}, 32'h1);
    $display("mode and id test done");
  endtask : t_mode
  task automatic t_sleep;
    go(CMD_SLEEP, 1);
    cyc(700);
    stat(32'h001);
    go(CMD_SLEEP);
    cyc(700);
    go(CMD_WRDIS);
    stat(32'h021);
    go(CMD_WAKE);
    go(CMD_WRDIS);
    cyc(1700);
    stat(32'h001);
    go(CMD_WRDIS);
    stat(32'h000);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_susp;
    go(CMD_WRITE_ENABLE_CMD);
    apb(1'b1, ADDR_START, 32'h1);
    go(CMD_RESUME);
    stat(32'h202);
    go(CMD_SUSP);
    cmp(st & 32'h8, 32'h0);
    stat(32'h20A);
    cyc(4000);
    stat(32'h208);
    go(CMD_WRITE_ENABLE_CMD);
    go(CMD_CE_A);
    stat(32'h289);
    go(CMD_RESUME);
    cyc(40);
    stat(32'h283);
    cyc(2100);
    apb(1'b1, ADDR_CLEAR, 32'h1);
    stat(32'h001);
    $display("suspend test done");
  endtask : t_susp
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    apb(1'b0, ADDR_CTRL, 32'h0);
    cmp(st, 32'h0);
    stat(32'h000);
    t_erase;
    t_mode;
    t_sleep;
    t_susp;
    summarize;
  end
  // Watchdog
  initial begin
    #200000;
    fails++;
    summarize;
  end
endmodule : testbench
